// ===== hw/soft_reset_defs.svh
`ifndef SOFT_RESET_DEFS_SVH
`define SOFT_RESET_DEFS_SVH

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define ADDR_W            8
`define DATA_W            32
`define PF_CTRL_OFS       8'h80
`define ENG_CTRL_OFS      8'h84

// ----------------------------------------------------------------
// field layout
// ----------------------------------------------------------------
`define PF_REG_W          7
`define PF_DOM_N          6
`define PF_SPARE_BIT      6
`define ENG_REG_W         2
`define ENG_DOM_N         2
`define DOM_N             8
`define PF_CTRL_RST       7'h00
`define ENG_CTRL_RST      2'h0
`define WORD_ZERO         32'h0000_0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_SYS_MHZ       25
`define GATED_WAIT_NS     1000
`define GATED_WAIT_CYC    ((`GATED_WAIT_NS * `CLK_SYS_MHZ + 999) / 1000)
`define WAIT_CNT_W        5

`endif

// ===== hw/soft_reset_pkg.sv
package soft_reset_pkg;
  `include "soft_reset_defs.svh"

  typedef logic [`ADDR_W-1:0]  bus_addr_t;
  typedef logic [`DATA_W-1:0]  bus_word_t;
  typedef logic [3:0]          bus_be_t;
  typedef logic [`PF_DOM_N-1:0]  pf_dom_t;
  typedef logic [`ENG_DOM_N-1:0] eng_dom_t;

  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_PF   = 2'b01,
    SEL_ENG  = 2'b10
  } reg_sel_t;

  typedef struct packed {
    logic waitrequest;
  } slave_state_t;

  typedef struct packed {
    logic                  rst_active;
    logic                  clk_prev;
    logic [`WAIT_CNT_W-1:0] wait_cnt;
  } release_state_t;

  typedef struct packed {
    logic [`PF_REG_W-1:0]  pf_ctrl;
    logic [`ENG_REG_W-1:0] eng_ctrl;
    bus_word_t             readdata;
  } ctrl_state_t;
endpackage : soft_reset_pkg

// ===== hw/avmm_slave_port.sv
`timescale 1ns/1ps
module avmm_slave_port (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // bus request
  input  wire logic read,
  input  wire logic write,
  // answer
  output logic      waitrequest,
  output logic      commit
);
  import soft_reset_pkg::*;

  slave_state_t st;
  slave_state_t next_st;

  // ----------------------------------------------------------------
  // one wait cycle, then the request completes on the next edge
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (st.waitrequest) begin
      if (read || write) begin
        next_st.waitrequest = 1'b0;
      end
    end else begin
      next_st.waitrequest = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st.waitrequest <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign waitrequest = st.waitrequest;
  // completion edge: master sees waitrequest low here
  assign commit      = (read || write) && !st.waitrequest;

  a_answer_next : assert property (@(posedge clk_sys) disable iff (!rst_b)
    (read || write) && st.waitrequest |=> !st.waitrequest)
    else $error("bus request not answered in one cycle");
endmodule : avmm_slave_port

// ===== hw/domain_release_sync.sv
`timescale 1ns/1ps
`include "soft_reset_defs.svh"
module domain_release_sync (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // control
  input  wire logic reset_req,
  input  wire logic dom_clk,
  // domain reset
  output logic      dom_reset
);
  import soft_reset_pkg::*;

  release_state_t st;
  release_state_t next_st;
  logic           clk_rise;

  assign clk_rise = dom_clk && !st.clk_prev;

  // ----------------------------------------------------------------
  // assert on request, release on a domain clock edge or on timeout
  // ----------------------------------------------------------------
  // the timeout lets a gated domain leave reset; without it a
  // stopped clock would hold the domain in reset forever
  always_comb begin
    next_st          = st;
    next_st.clk_prev = dom_clk;
    if (reset_req) begin
      next_st.rst_active = 1'b1;
      next_st.wait_cnt   = '0;
    end else if (st.rst_active) begin
      if (clk_rise) begin
        next_st.rst_active = 1'b0;
      end else if (st.wait_cnt == `WAIT_CNT_W'(`GATED_WAIT_CYC - 1)) begin
        next_st.rst_active = 1'b0;
      end else begin
        next_st.wait_cnt = st.wait_cnt + `WAIT_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dom_reset = st.rst_active;

  a_release_on_edge : assert property (@(posedge clk_sys) disable iff (!rst_b) // RL3
    st.rst_active && !reset_req && clk_rise |=> !st.rst_active)
    else $error("release missed a domain clock edge");
endmodule : domain_release_sync

// ===== hw/domain_soft_reset_control.sv
// Contract
// (RL1) a one written to a domain bit asserts that domain's reset at the write edge, no domain clock needed.
// (RL2) a zero written to a domain bit removes that reset; the stored bit alone decides it.
// (RL3) release follows the domain clock and still completes when that clock is gated off.
// (RL4) a set bit never clears itself; firmware must write it back to zero.
// (RL5) each domain has its own reset output and bit; fabric register at 0x080 uses bits 6:0.
// (RL6) fabric bit 6 is plain storage, resets to zero and drives no reset.
// (RL7) engine register at 0x084 holds reset bits 1 and 0; bits 31:2 reserved.
// (RL8) reserved bits read zero and ignore writes; all reset bits power up cleared.
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ps
`include "soft_reset_defs.svh"
module domain_soft_reset_control (
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rst_b,
  // avalon-mm slave
  input  wire soft_reset_pkg::bus_addr_t address,
  input  wire logic                     read,
  input  wire logic                     write,
  input  wire soft_reset_pkg::bus_be_t   byteenable,
  input  wire soft_reset_pkg::bus_word_t writedata,
  output soft_reset_pkg::bus_word_t      readdata,
  output logic                          waitrequest,
  // peripheral fabric domains
  input  wire soft_reset_pkg::pf_dom_t   pf_domain_clk,
  output soft_reset_pkg::pf_dom_t        pf_domain_reset,
  // sensor processing engine domains
  input  wire soft_reset_pkg::eng_dom_t  engine_domain_clk,
  output soft_reset_pkg::eng_dom_t       engine_domain_reset
);
  import soft_reset_pkg::*;

  ctrl_state_t st;
  ctrl_state_t next_st;
  logic        commit;
  reg_sel_t    sel;
  logic [`DOM_N-1:0] dom_req;
  logic [`DOM_N-1:0] dom_clk;
  logic [`DOM_N-1:0] dom_reset;

  localparam int REL_MAX_CYC = `GATED_WAIT_CYC + 1;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic reg_sel_t reg_select(input bus_addr_t addr);
    reg_select = SEL_NONE;
    if (addr == `PF_CTRL_OFS) begin
      reg_select = SEL_PF;
    end else if (addr == `ENG_CTRL_OFS) begin
      reg_select = SEL_ENG;
    end
  endfunction : reg_select

  function automatic bus_word_t read_value(input reg_sel_t s,
                                           input ctrl_state_t c);
    read_value = `WORD_ZERO;
    unique case (s)
      SEL_PF: begin
        read_value[`PF_REG_W-1:0] = c.pf_ctrl; // RL8
      end
      SEL_ENG: begin
        read_value[`ENG_REG_W-1:0] = c.eng_ctrl; // RL8
      end
      default: begin
        read_value = `WORD_ZERO;
      end
    endcase
  endfunction : read_value

  assign sel = reg_select(address);

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  avmm_slave_port u_slave (
    .clk_sys     (clk_sys),
    .rst_b       (rst_b),
    .read        (read),
    .write       (write),
    .waitrequest (waitrequest),
    .commit      (commit)
  );

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // bits change only on a bus write, so a set bit stays set
  // readdata is loaded while read is high, so the answer stands from the edge
  // that drops waitrequest and is cleared once read drops
  always_comb begin
    next_st          = st;
    next_st.readdata = `WORD_ZERO;
    if (read) begin
      next_st.readdata = read_value(sel, st);
    end
    if (commit && write && byteenable[0]) begin
      unique case (sel)
        SEL_PF: begin
          next_st.pf_ctrl = writedata[`PF_REG_W-1:0]; // RL1 RL2 RL5
        end
        SEL_ENG: begin
          next_st.eng_ctrl = writedata[`ENG_REG_W-1:0]; // RL1 RL2 RL7
        end
        default: begin
          next_st = next_st; // RL8
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st.pf_ctrl  <= `PF_CTRL_RST; // RL8
      st.eng_ctrl <= `ENG_CTRL_RST; // RL8
      st.readdata <= `WORD_ZERO;
    end else begin
      st <= next_st; // RL4
    end
  end

  assign readdata = st.readdata;

  // ----------------------------------------------------------------
  // per-domain reset generation
  // ----------------------------------------------------------------
  // the next bit value is fed forward so the output rises on the
  // very edge that stores the bit; the spare bit 6 is not wired
  // domain clocks are sampled by clk_sys: one faster than half of
  // clk_sys can slip edges, and its domain then leaves on the timeout
  assign dom_req = {next_st.eng_ctrl, next_st.pf_ctrl[`PF_DOM_N-1:0]}; // RL6
  assign dom_clk = {engine_domain_clk, pf_domain_clk};

  generate
    for (genvar d = 0; d < `DOM_N; d++) begin : g_dom
      domain_release_sync u_sync (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .reset_req (dom_req[d]), // RL1
        .dom_clk   (dom_clk[d]), // RL3
        .dom_reset (dom_reset[d])
      );
    end
  endgenerate

  assign pf_domain_reset     = dom_reset[`PF_DOM_N-1:0]; // RL5
  assign engine_domain_reset = dom_reset[`DOM_N-1:`PF_DOM_N]; // RL5

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  // all checks stop while rst_b is low

  sequence s_pf_write;
    commit && write && byteenable[0] && sel == SEL_PF;
  endsequence

  sequence s_eng_write;
    commit && write && byteenable[0] && sel == SEL_ENG;
  endsequence

  sequence s_pf0_cleared;
    $fell(st.pf_ctrl[0]);
  endsequence

  a_assert_at_once : assert property ( // RL1
    s_pf_write ##0 writedata[0] |=> pf_domain_reset[0])
    else $error("domain reset not asserted at write edge");

  a_eng_assert_once : assert property ( // RL1
    s_eng_write ##0 writedata[1] |=> engine_domain_reset[1])
    else $error("engine reset not asserted at write edge");

  a_bit_takes_write : assert property ( // RL2
    s_pf_write |=> st.pf_ctrl == $past(writedata[`PF_REG_W-1:0]))
    else $error("fabric register did not take written value");

  a_release_bounded : assert property ( // RL3
    s_pf0_cleared |-> ##[0:REL_MAX_CYC] (!pf_domain_reset[0] || st.pf_ctrl[0]))
    else $error("fabric reset release not completed in time");

  a_no_self_clear : assert property ( // RL4
    !commit |=> $stable(st.pf_ctrl) && $stable(st.eng_ctrl))
    else $error("control bit changed without a write");

  a_reset_while_set : assert property ( // RL4
    st.pf_ctrl[`PF_DOM_N-1:0] != '0 |->
      (pf_domain_reset & st.pf_ctrl[`PF_DOM_N-1:0]) == st.pf_ctrl[`PF_DOM_N-1:0])
    else $error("set bit without active domain reset");

  // an engine reset may still be finishing its release, so only a rise counts
  a_domains_independent : assert property ( // RL5
    s_pf_write |=>
      $stable(st.eng_ctrl) && (engine_domain_reset & ~$past(engine_domain_reset)) == '0)
    else $error("fabric write disturbed engine domains");

  a_spare_no_effect : assert property ( // RL6
    st.pf_ctrl[`PF_DOM_N-1:0] == '0 && pf_domain_reset == '0 |=>
      (pf_domain_reset == '0 || st.pf_ctrl[`PF_DOM_N-1:0] != '0))
    else $error("spare bit produced a domain reset");

  a_eng_takes_write : assert property ( // RL7
    s_eng_write |=> st.eng_ctrl == $past(writedata[`ENG_REG_W-1:0]))
    else $error("engine register did not take written value");

  a_reserved_zero : assert property ( // RL8
    read && !waitrequest |->
      readdata[`DATA_W-1:`PF_REG_W] == '0 &&
      (sel != SEL_ENG || readdata[`DATA_W-1:`ENG_REG_W] == '0) &&
      (sel != SEL_NONE || readdata == '0))
    else $error("reserved or unmapped bits read nonzero");

  a_read_matches : assert property (
    read && !waitrequest && sel == SEL_PF |->
      readdata[`PF_REG_W-1:0] == st.pf_ctrl)
    else $error("fabric register readback mismatch");

  a_eng_read_matches : assert property ( // RL7
    read && !waitrequest && sel == SEL_ENG |->
      readdata[`ENG_REG_W-1:0] == st.eng_ctrl)
    else $error("engine register readback mismatch");

  a_eng_bit0_now : assert property ( // RL1
    s_eng_write ##0 writedata[0] |=> engine_domain_reset[0])
    else $error("engine bit 0 reset not asserted at write edge");

  a_eng_held : assert property ( // RL4
    st.eng_ctrl != '0 |->
      (engine_domain_reset & st.eng_ctrl) == st.eng_ctrl)
    else $error("engine bit set without active domain reset");

  a_eng_write_isolated : assert property ( // RL5
    s_eng_write |=>
      $stable(st.pf_ctrl) && (pf_domain_reset & ~$past(pf_domain_reset)) == '0)
    else $error("engine write disturbed fabric domains");

  a_spare_stored : assert property ( // RL6
    s_pf_write |=> st.pf_ctrl[`PF_SPARE_BIT] == $past(writedata[`PF_SPARE_BIT]))
    else $error("spare bit did not take written value");

  a_read_keeps_bits : assert property ( // RL4
    commit && read |=> $stable(st.pf_ctrl) && $stable(st.eng_ctrl))
    else $error("read access changed a control bit");

  sequence s_none_write;
    commit && write && byteenable[0] && sel == SEL_NONE;
  endsequence

  a_unmapped_ignored : assert property ( // RL8
    s_none_write |=> $stable(st.pf_ctrl) && $stable(st.eng_ctrl))
    else $error("unmapped write changed a control bit");

  a_masked_ignored : assert property ( // RL8
    commit && write && !byteenable[0] |=>
      $stable(st.pf_ctrl) && $stable(st.eng_ctrl))
    else $error("write without byte lane 0 changed a control bit");

  // ----------------------------------------------------------------
  // bus timing checks
  // ----------------------------------------------------------------
  // software polls on waitrequest, so a slave that forgets to raise
  // it again would let the next access complete without a wait
  sequence s_bus_req;
    (read || write) && waitrequest;
  endsequence

  sequence s_bus_done;
    !waitrequest ##1 waitrequest;
  endsequence

  a_one_wait_state : assert property (
    s_bus_req |=> s_bus_done)
    else $error("bus access did not complete after one wait cycle");

  a_wait_high_idle : assert property (
    !(read || write) |=> waitrequest)
    else $error("waitrequest low with no access pending");

  a_idle_read_zero : assert property (
    !read |=> readdata == `WORD_ZERO)
    else $error("read data not cleared after the access");

  // ----------------------------------------------------------------
  // per-domain checks
  // ----------------------------------------------------------------
  // same checks on every dom_req and dom_reset bit; they stop before the output slices,
  // so a slip in the pf_domain_reset or engine_domain_reset wiring is not seen here
  generate
    for (genvar k = 0; k < `DOM_N; k++) begin : g_chk
      a_dom_set_now : assert property ( // RL1
        dom_req[k] |=> dom_reset[k])
        else $error("domain reset missing while its bit is set");

      a_dom_stays_off : assert property ( // RL2
        !dom_req[k] && !dom_reset[k] |=> !dom_reset[k])
        else $error("domain reset rose without its bit");

      a_dom_release_time : assert property ( // RL3
        $fell(dom_req[k]) |-> ##[0:REL_MAX_CYC] (!dom_reset[k] || dom_req[k]))
        else $error("domain reset release took too long");
    end
  endgenerate
endmodule : domain_soft_reset_control

// ===== verif/testbench.sv
`timescale 1ns/1ps
`include "soft_reset_defs.svh"
module testbench;
  import soft_reset_pkg::*;

  // ----------------------------------------------------------------
  // design connections
  // ----------------------------------------------------------------
  logic      clk_sys;
  logic      rst_b;
  bus_addr_t address;
  logic      read;
  logic      write;
  bus_be_t   byteenable;
  bus_word_t writedata;
  bus_word_t readdata;
  logic      waitrequest;
  pf_dom_t   pf_domain_clk;
  pf_dom_t   pf_domain_reset;
  eng_dom_t  engine_domain_clk;
  eng_dom_t  engine_domain_reset;
  logic      dclk_run;
  int        fails;
  int        tests_run;
  int        cycles;
  bus_word_t rd;

  domain_soft_reset_control domain_soft_reset_control_inst (
    .clk_sys             (clk_sys),
    .rst_b               (rst_b),
    .address             (address),
    .read                (read),
    .write               (write),
    .byteenable          (byteenable),
    .writedata           (writedata),
    .readdata            (readdata),
    .waitrequest         (waitrequest),
    .pf_domain_clk       (pf_domain_clk),
    .pf_domain_reset     (pf_domain_reset),
    .engine_domain_clk   (engine_domain_clk),
    .engine_domain_reset (engine_domain_reset)
  );

  // ----------------------------------------------------------------
  // clocks and timeout
  // ----------------------------------------------------------------
  always #20 clk_sys = ~clk_sys;

  // domain clocks run at a quarter of clk_sys so every edge is seen
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (dclk_run && cycles[0]) begin
      pf_domain_clk     <= ~pf_domain_clk;
      engine_domain_clk <= ~engine_domain_clk;
    end
  end

  always @(posedge clk_sys) begin
    if (cycles == 20000) begin
      fails++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // helper tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input bus_word_t seen, input bus_word_t exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // request held until waitrequest is sampled low, then released
  task automatic bus_access(input logic rw, input bus_addr_t a, input bus_word_t d,
                            input bus_be_t be, output bus_word_t q);
    @(posedge clk_sys);
    address    <= a;
    writedata  <= d;
    byteenable <= be;
    read       <= ~rw;
    write      <= rw;
    do begin
      @(posedge clk_sys);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus_access

  task automatic bus_write(input bus_addr_t a, input bus_word_t d, input bus_be_t be);
    bus_word_t q;
    bus_access(1'b1, a, d, be, q);
    #1;
  endtask : bus_write

  task automatic bus_read(input bus_addr_t a, output bus_word_t q);
    bus_access(1'b0, a, 32'h0000_0000, 4'hF, q);
  endtask : bus_read

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    rst_b = 1'b0;
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'h0;
    writedata = 32'h0000_0000;
    pf_domain_clk = 6'h00;
    engine_domain_clk = 2'h0;
    dclk_run = 1'b0;
    fails = 0;
    tests_run = 0;
    cycles = 0;
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);

    bus_read(8'h80, rd);
    check("fabric reg", rd, 32'h0000_0000);
    bus_read(8'h84, rd);
    check("engine reg", rd, 32'h0000_0000);
    check("fabric resets", 32'(pf_domain_reset), 32'h0000_0000);
    check("engine resets", 32'(engine_domain_reset), 32'h0000_0000);
    $display("test reset values done");

    // domain clocks stand still: assertion must not need them
    bus_write(8'h80, 32'hFFFF_FFFF, 4'hF);
    check("fabric resets", 32'(pf_domain_reset), 32'h0000_003F);
    bus_write(8'h84, 32'hFFFF_FFFF, 4'hF);
    check("engine resets", 32'(engine_domain_reset), 32'h0000_0003);
    bus_read(8'h80, rd);
    check("fabric reg", rd, 32'h0000_007F);
    bus_read(8'h84, rd);
    check("engine reg", rd, 32'h0000_0003);
    repeat (50) @(posedge clk_sys);
    check("fabric held", 32'(pf_domain_reset), 32'h0000_003F);
    $display("test assert done");

    // release with gated clocks relies on the fallback wait
    bus_write(8'h80, 32'h0000_0040, 4'h1);
    check("fabric release start", 32'(pf_domain_reset), 32'h0000_003F);
    repeat (`GATED_WAIT_CYC + 5) @(posedge clk_sys);
    #1;
    check("fabric gated release", 32'(pf_domain_reset), 32'h0000_0000);
    bus_read(8'h80, rd);
    check("spare bit", rd, 32'h0000_0040);
    dclk_run <= 1'b1;
    bus_write(8'h84, 32'h0000_0000, 4'h1);
    repeat (8) @(posedge clk_sys);
    #1;
    check("engine clocked release", 32'(engine_domain_reset), 32'h0000_0000);
    $display("test release done");

    for (int i = 0; i < 6; i++) begin
      bus_write(8'h80, 32'h0000_0001 << i, 4'h1);
      check("fabric single", 32'(pf_domain_reset), 32'h0000_0001 << i);
      bus_write(8'h80, 32'h0000_0000, 4'h1);
      repeat (8) @(posedge clk_sys);
      check("fabric single off", 32'(pf_domain_reset), 32'h0000_0000);
    end
    for (int j = 0; j < 2; j++) begin
      // let the previous engine bit finish its release first
      bus_write(8'h84, 32'h0000_0000, 4'h1);
      repeat (8) @(posedge clk_sys);
      #1;
      check("engine single off", 32'(engine_domain_reset), 32'h0000_0000);
      bus_write(8'h84, 32'h0000_0001 << j, 4'h1);
      check("engine single", 32'(engine_domain_reset), 32'h0000_0001 << j);
      check("fabric untouched", 32'(pf_domain_reset), 32'h0000_0000);
    end
    $display("test independence done");

    bus_write(8'h88, 32'hFFFF_FFFF, 4'hF);
    bus_read(8'h88, rd);
    check("unmapped", rd, 32'h0000_0000);
    bus_write(8'h80, 32'h0000_003F, 4'h0);
    bus_read(8'h80, rd);
    check("masked write", rd, 32'h0000_0000);
    check("masked resets", 32'(pf_domain_reset), 32'h0000_0000);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    bus_read(8'h84, rd);
    check("engine after reset", rd, 32'h0000_0000);
    check("engine resets cleared", 32'(engine_domain_reset), 32'h0000_0000);
    $display("test refusals done");
    finish_test();
  end
endmodule : testbench
